// ==== rtl/adc_serial_config_readout.sv ====
// Serial configuration write and result readback of a multichannel converter.
`include "adc_serial_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_serial_config_readout #(
  parameter int CONV_CYCLES = (`ACFG_CONV_TIME_NS * 1000 + `ACFG_CLK_PERIOD_PS - 1) / `ACFG_CLK_PERIOD_PS,
  parameter int WINDOW_CYCLES = (`ACFG_DATA_WINDOW_NS * 1000) / `ACFG_CLK_PERIOD_PS,
  parameter int BUF_DEPTH = `ACFG_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic conversion_start,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_en_n,
  input wire logic result_valid,
  input wire logic [`ACFG_RESULT_BITS-1:0] result_data,
  output logic result_ready,
  output logic convert_pulse,
  output logic converter_power,
  output adc_serial_pkg::cfg_s converter_config_word,
  output adc_serial_pkg::ref_ctrl_s ref_ctrl,
  output logic [2:0] mux_channel,
  output logic mux_temp
);
  localparam int CW = 16;
  initial begin
    if (CONV_CYCLES < 1 || CONV_CYCLES >= 65536 || WINDOW_CYCLES < 1 || WINDOW_CYCLES >= 65536) begin
      $error("Timing counts out of range.");
    end
    if (BUF_DEPTH != `ACFG_BUF_DEPTH) begin
      $error("Buffer depth must be two.");
    end
  end

  // Two-stage synchronisers for the pins, then a third stage for edge detection.
  logic [2:0] cnv_s, sck_s, sdi_s;
  logic [2:0] next_cnv_s, next_sck_s, next_sdi_s;
  always_comb begin
    next_cnv_s = {cnv_s[1:0], conversion_start};
    next_sck_s = {sck_s[1:0], serial_clock};
    next_sdi_s = {sdi_s[1:0], serial_data_in};
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnv_s <= 3'h7;
      sck_s <= 3'h0;
      sdi_s <= 3'h0;
    end else begin
      cnv_s <= next_cnv_s;
      sck_s <= next_sck_s;
      sdi_s <= next_sdi_s;
    end
  end
  logic cnv_rise, cnv_fall, sck_rise, sck_fall, cnv_low, sdi;
  assign cnv_rise = cnv_s[1] && !cnv_s[2];
  assign cnv_fall = !cnv_s[1] && cnv_s[2];
  assign sck_rise = sck_s[1] && !sck_s[2];
  assign sck_fall = !sck_s[1] && sck_s[2];
  assign cnv_low = !cnv_s[1];
  assign sdi = sdi_s[1];

  // Conversion control, conversion timer and safe transfer window timer.
  adc_serial_pkg::conv_state_e state, next_state;
  logic [CW-1:0] conv_cnt, next_conv_cnt, win_cnt, next_win_cnt;
  logic next_convert_pulse, next_converter_power, win_expire;
  adc_serial_pkg::cfg_s conv_cfg, next_conv_cfg;
  logic start_conv;
  assign start_conv = cnv_rise && state == adc_serial_pkg::ST_ACQUIRE;
  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_win_cnt = win_cnt;
    next_conv_cfg = conv_cfg;
    next_convert_pulse = 1'b0;
    next_converter_power = converter_power;
    win_expire = 1'b0;
    if (win_cnt != '0) begin
      next_win_cnt = win_cnt - 1'b1;
      win_expire = win_cnt == CW'(1);
    end
    unique case (state)
      adc_serial_pkg::ST_ACQUIRE: begin
        if (start_conv) begin
          next_state = adc_serial_pkg::ST_CONVERT;
          next_conv_cnt = CW'(CONV_CYCLES);
          next_win_cnt = CW'(WINDOW_CYCLES);
          next_conv_cfg = converter_config_word;
          next_convert_pulse = 1'b1;
          next_converter_power = 1'b1;
        end
      end
      adc_serial_pkg::ST_CONVERT: begin
        // The start pin is not looked at until the count runs out.
        next_conv_cnt = conv_cnt - 1'b1;
        if (conv_cnt == CW'(1)) begin
          next_state = adc_serial_pkg::ST_ACQUIRE;
          next_converter_power = 1'b0;
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= adc_serial_pkg::ST_ACQUIRE;
      conv_cnt <= '0;
      win_cnt <= '0;
      conv_cfg <= `ACFG_CFG_RESET;
      convert_pulse <= 1'b0;
      converter_power <= 1'b0;
    end else begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      win_cnt <= next_win_cnt;
      conv_cfg <= next_conv_cfg;
      convert_pulse <= next_convert_pulse;
      converter_power <= next_converter_power;
    end
  end

  // Two-entry result buffer: result word paired with the configuration it was taken under.
  adc_serial_pkg::entry_s mem [BUF_DEPTH];
  logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0] count, next_count;
  logic push, pop, load_xfer, next_result_ready;
  adc_serial_pkg::entry_s head;
  assign head = mem[rd_ptr];
  assign push = result_valid && result_ready;
  // An unread result still held when the window elapses is dropped.
  assign pop = (load_xfer || win_expire) && count != 2'h0;
  always_comb begin
    next_wr_ptr = wr_ptr ^ push;
    next_rd_ptr = rd_ptr ^ pop;
    next_count = count + {1'b0, push} - {1'b0, pop};
    next_result_ready = next_count < 2'(BUF_DEPTH);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      result_ready <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      result_ready <= next_result_ready;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= '{result: result_data, cfg: conv_cfg};
    end
  end

  // Serial shifting: result and optional readback out on falls, configuration in on rises.
  logic [29:0] shift_out, next_shift_out;
  logic [13:0] shift_in, next_shift_in;
  logic [4:0] fall_cnt, next_fall_cnt, fall_limit, next_fall_limit;
  logic [3:0] rise_cnt, next_rise_cnt;
  logic out_active, next_out_active, in_active, next_in_active;
  logic next_sdo, next_sdo_en_n, cfg_write;
  adc_serial_pkg::entry_s load_word;
  always_comb begin
    next_shift_out = shift_out;
    next_shift_in = shift_in;
    next_fall_cnt = fall_cnt;
    next_fall_limit = fall_limit;
    next_rise_cnt = rise_cnt;
    next_out_active = out_active;
    next_in_active = in_active;
    next_sdo = serial_data_out;
    next_sdo_en_n = serial_data_out_en_n;
    load_xfer = 1'b0;
    cfg_write = 1'b0;
    load_word = count != 2'h0 ? head : '0;
    if (cnv_rise) begin
      // Output floats and any partial configuration is thrown away.
      next_sdo_en_n = 1'b1;
      next_out_active = 1'b0;
      next_in_active = 1'b0;
      next_rise_cnt = 4'h0;
    end else if (cnv_fall && state == adc_serial_pkg::ST_ACQUIRE) begin
      load_xfer = 1'b1;
      next_shift_out = {load_word.result, load_word.cfg};
      next_sdo = load_word.result[`ACFG_RESULT_BITS-1];
      next_sdo_en_n = 1'b0;
      next_out_active = 1'b1;
      next_in_active = 1'b1;
      next_fall_cnt = 5'h0;
      next_rise_cnt = 4'h0;
      next_fall_limit = converter_config_word.readback_disable ?
          `ACFG_RESULT_FALLS : `ACFG_READBACK_FALLS;
    end else begin
      if (sck_fall && out_active && cnv_low) begin
        // Output changes only after a fall, so it stands across the next rise and fall.
        next_shift_out = {shift_out[28:0], 1'b0};
        next_sdo = shift_out[28];
        next_fall_cnt = fall_cnt + 1'b1;
        if (fall_cnt + 1'b1 == fall_limit) begin
          next_sdo_en_n = 1'b1;
          next_out_active = 1'b0;
        end
      end
      if (sck_rise && in_active && cnv_low) begin
        next_shift_in = {shift_in[12:0], sdi};
        next_rise_cnt = rise_cnt + 1'b1;
        if (rise_cnt + 1'b1 == `ACFG_CFG_RISES) begin
          next_in_active = 1'b0;
          cfg_write = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_out <= '0;
      shift_in <= '0;
      fall_cnt <= 5'h0;
      fall_limit <= `ACFG_RESULT_FALLS;
      rise_cnt <= 4'h0;
      out_active <= 1'b0;
      in_active <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_out_en_n <= 1'b1;
    end else begin
      shift_out <= next_shift_out;
      shift_in <= next_shift_in;
      fall_cnt <= next_fall_cnt;
      fall_limit <= next_fall_limit;
      rise_cnt <= next_rise_cnt;
      out_active <= next_out_active;
      in_active <= next_in_active;
      serial_data_out <= next_sdo;
      serial_data_out_en_n <= next_sdo_en_n;
    end
  end

  // Configuration word, reference decode and channel sequencer.
  adc_serial_pkg::cfg_s next_cfg, new_cfg;
  adc_serial_pkg::ref_ctrl_s next_ref_ctrl;
  logic [2:0] next_mux_channel;
  logic next_mux_temp, scan;
  assign new_cfg = {shift_in[12:0], sdi};
  always_comb begin
    next_cfg = converter_config_word;
    if (cfg_write && new_cfg.config_update) begin
      next_cfg = new_cfg;
    end
    unique case (next_cfg.reference_select)
      adc_serial_pkg::REF_INT_2V5: next_ref_ctrl = 4'b1001;
      adc_serial_pkg::REF_INT_4V096: next_ref_ctrl = 4'b1101;
      adc_serial_pkg::REF_EXT_TEMP: next_ref_ctrl = 4'b0001;
      adc_serial_pkg::REF_EXT_BUF_TEMP: next_ref_ctrl = 4'b0011;
      adc_serial_pkg::REF_EXT_BUF: next_ref_ctrl = 4'b0010;
      default: next_ref_ctrl = 4'b0000;
    endcase
    scan = next_cfg.sequence_mode == adc_serial_pkg::SEQ_SCAN_TEMP ||
        next_cfg.sequence_mode == adc_serial_pkg::SEQ_SCAN;
    next_mux_channel = mux_channel;
    next_mux_temp = mux_temp;
    if (cfg_write && new_cfg.config_update && new_cfg.sequence_mode != adc_serial_pkg::SEQ_UPDATE) begin
      next_mux_channel = scan ? 3'h0 : next_cfg.channel_select;
      next_mux_temp = 1'b0;
    end else if (start_conv && scan) begin
      // The scan steps after each conversion start.
      if (mux_temp || (mux_channel == next_cfg.channel_select &&
          next_cfg.sequence_mode == adc_serial_pkg::SEQ_SCAN)) begin
        next_mux_channel = 3'h0;
        next_mux_temp = 1'b0;
      end else if (mux_channel == next_cfg.channel_select) begin
        next_mux_temp = 1'b1;
      end else begin
        next_mux_channel = mux_channel + 1'b1;
      end
    end else if (next_cfg.sequence_mode == adc_serial_pkg::SEQ_OFF) begin
      next_mux_channel = next_cfg.channel_select;
      next_mux_temp = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      converter_config_word <= `ACFG_CFG_RESET;
      ref_ctrl <= 4'b0010;
      mux_channel <= 3'h0;
      mux_temp <= 1'b0;
    end else begin
      converter_config_word <= next_cfg;
      ref_ctrl <= next_ref_ctrl;
      mux_channel <= next_mux_channel;
      mux_temp <= next_mux_temp;
    end
  end
endmodule : adc_serial_config_readout
`default_nettype wire

// ==== include/adc_serial_defs.svh ====
// Field positions, sizes, reset values and timing figures of the converter serial port.
`ifndef ADC_SERIAL_DEFS_SVH
`define ADC_SERIAL_DEFS_SVH
`define ACFG_CFG_BITS 14
`define ACFG_RESULT_BITS 16
`define ACFG_UPDATE_BIT 13
`define ACFG_RB_BIT 0
`define ACFG_CFG_RESET 14'h3fff
`define ACFG_RESULT_FALLS 5'h10
`define ACFG_READBACK_FALLS 5'h1e
`define ACFG_CFG_RISES 4'he
`define ACFG_CLK_PERIOD_PS 4000
`define ACFG_CONV_TIME_NS 2200
`define ACFG_DATA_WINDOW_NS 1200
`define ACFG_BUF_DEPTH 2
`endif

// ==== include/adc_serial_pkg.sv ====
// Types shared by the converter serial port and configuration logic.
package adc_serial_pkg;
  typedef enum logic [2:0] {
    REF_INT_2V5 = 3'b000,
    REF_INT_4V096 = 3'b001,
    REF_EXT_TEMP = 3'b010,
    REF_EXT_BUF_TEMP = 3'b011,
    REF_SPARE_A = 3'b100,
    REF_SPARE_B = 3'b101,
    REF_EXT = 3'b110,
    REF_EXT_BUF = 3'b111
  } ref_sel_e;
  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_UPDATE = 2'b01,
    SEQ_SCAN_TEMP = 2'b10,
    SEQ_SCAN = 2'b11
  } seq_mode_e;
  typedef enum logic [0:0] {
    ST_ACQUIRE = 1'b0,
    ST_CONVERT = 1'b1
  } conv_state_e;
  typedef struct packed {
    logic config_update;
    logic [2:0] input_config;
    logic [2:0] channel_select;
    logic full_bandwidth;
    ref_sel_e reference_select;
    seq_mode_e sequence_mode;
    logic readback_disable;
  } cfg_s;
  typedef struct packed {
    logic internal_ref_on;
    logic ref_4v096;
    logic ref_buffer_on;
    logic temp_sensor_on;
  } ref_ctrl_s;
  typedef struct packed {
    logic [15:0] result;
    cfg_s cfg;
  } entry_s;
endpackage : adc_serial_pkg

// ==== bench/adc_serial_config_readout_checker.sv ====
// Assertions on the converter serial port and configuration outputs.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_config_readout_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic conversion_start,
  input wire logic serial_clock,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en_n,
  input wire logic convert_pulse,
  input wire logic converter_power,
  input wire adc_serial_pkg::cfg_s converter_config_word,
  input wire adc_serial_pkg::ref_ctrl_s ref_ctrl,
  input wire logic [2:0] mux_channel
);
  wire [2:0] ref_code = converter_config_word.reference_select;
  wire [1:0] seq_code = converter_config_word.sequence_mode;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_sdo_held;
    $stable(serial_data_out) [*5];
  endsequence
  property p_float_on_start; convert_pulse |-> serial_data_out_en_n; endproperty
  a_float_on_start: assert property (p_float_on_start) else $error("output driven at start");
  property p_power_hold; convert_pulse |=> converter_power [*8]; endproperty
  a_power_hold: assert property (p_power_hold) else $error("conversion cut short");
  property p_conv_floats; converter_power |-> serial_data_out_en_n; endproperty
  a_conv_floats: assert property (p_conv_floats) else $error("output driven in conversion");
  property p_cfg_update; !$stable(converter_config_word) |-> converter_config_word.config_update; endproperty
  a_cfg_update: assert property (p_cfg_update) else $error("config changed without update");
  property p_cfg_low; !$stable(converter_config_word) |-> !conversion_start; endproperty
  a_cfg_low: assert property (p_cfg_low) else $error("config changed outside transfer");
  property p_ref_int; ref_code[2:1] == 2'h0 |-> ref_ctrl.internal_ref_on && ref_ctrl.ref_4v096 == ref_code[0];
  endproperty
  a_ref_int: assert property (p_ref_int) else $error("internal reference wrong");
  property p_ref_ext; ref_code[1] |-> ref_ctrl == {2'h0, ref_code[0], !ref_code[2]}; endproperty
  a_ref_ext: assert property (p_ref_ext) else $error("external reference wrong");
  property p_mux_off; seq_code == 2'h0 |-> mux_channel == converter_config_word.channel_select; endproperty
  a_mux_off: assert property (p_mux_off) else $error("channel not followed");
  property p_sdo_held; !serial_data_out_en_n && $rose(serial_clock) |-> ##1 s_sdo_held; endproperty
  a_sdo_held: assert property (p_sdo_held) else $error("output moved near rise");
endmodule : adc_serial_config_readout_checker
bind adc_serial_config_readout adc_serial_config_readout_checker u_adc_serial_config_readout_checker (
  .clk, .nrst, .conversion_start, .serial_clock, .serial_data_out, .serial_data_out_en_n,
  .convert_pulse, .converter_power, .converter_config_word, .ref_ctrl, .mux_channel);
`default_nettype wire

// ==== bench/host_spi_model.sv ====
// Host controller model driving the converter serial pins in clock mode zero.
`timescale 1ns/1ps
`default_nettype none
module host_spi_model #(
  parameter int CONV_WAIT = 600
) (
  input wire logic clk,
  output logic conversion_start,
  output logic serial_clock,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en_n
);
  initial begin
    conversion_start = 1'b1;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  task automatic frame(input logic [13:0] w, input int n, output logic [29:0] got);
    got = 30'h0;
    @(posedge clk);
    conversion_start <= 1'b0;
    repeat (4) @(posedge clk);
    conversion_start <= 1'b1;
    repeat (CONV_WAIT) @(posedge clk);
    conversion_start <= 1'b0;
    serial_data_in <= w[13];
    for (int k = 0; k < n; k++) begin
      repeat (4) @(posedge clk);
      serial_clock <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      got = {got[28:0], serial_data_out_en_n ? 1'bx : serial_data_out};
      @(posedge clk);
      serial_clock <= 1'b0;
      serial_data_in <= k < 13 ? w[12 - k] : ~serial_data_in;
    end
    repeat (8) @(posedge clk);
    serial_data_in <= ~serial_data_in;
  endtask : frame
endmodule : host_spi_model
`default_nettype wire

// ==== bench/test_adc_serial_config_readout.sv ====
// Self-checking bench for the converter serial port and configuration logic.
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_config_readout;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic conversion_start;
  logic serial_clock;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_en_n;
  logic result_valid = 1'b0;
  logic [15:0] result_data = 16'h8001;
  logic result_ready;
  logic convert_pulse;
  logic converter_power;
  logic power_q = 1'b0;
  adc_serial_pkg::cfg_s converter_config_word;
  adc_serial_pkg::ref_ctrl_s ref_ctrl;
  logic [2:0] mux_channel;
  logic mux_temp;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  int error_cnt = 0;
  int num_checks = 0;
  int pulses = 0;
  always #2 clk = ~clk;
  adc_serial_config_readout #(.CONV_CYCLES(20), .WINDOW_CYCLES(10)) u_adc_serial_config_readout (
    .clk, .nrst, .conversion_start, .serial_clock, .serial_data_in, .serial_data_out, .serial_data_out_en_n,
    .result_valid, .result_data, .result_ready, .convert_pulse, .converter_power, .converter_config_word,
    .ref_ctrl, .mux_channel, .mux_temp);
  host_spi_model #(.CONV_WAIT(32)) u_host_spi_model (
    .clk, .conversion_start, .serial_clock, .serial_data_in, .serial_data_out, .serial_data_out_en_n);
  // The converter core hands over a fresh word when each conversion ends.
  always @(posedge clk) begin
    power_q <= converter_power;
    if (convert_pulse) begin
      pulses <= pulses + 1;
    end
    if (power_q && !converter_power) begin
      result_data <= result_data + 16'h4e6d;
      result_valid <= 1'b1;
    end else if (result_ready) begin
      result_valid <= 1'b0;
    end
  end
  task automatic check(input logic [29:0] got, input logic [29:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    logic [29:0] got;
    logic [13:0] w;
    logic [3:0] mk;
    logic [3:0] ex;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    check(ref_ctrl, 4'h2);
    for (int i = 0; i < 6; i++) begin
      w = {1'b1, 3'h7, codes[i], 1'b1, codes[i], 2'h0, 1'b1};
      u_host_spi_model.frame(w, 16, got);
      mk = codes[i][1] ? 4'hf : 4'hc;
      ex = {codes[i][2:1] == 2'h0, codes[i] == 3'h1, codes[i][0], !codes[i][2]};
      check(converter_config_word, w);
      check(got[15:0], result_data);
      check(serial_data_out_en_n, 1'b1);
      check(converter_power, 1'b0);
      check(mux_channel, codes[i]);
      check(ref_ctrl & mk, ex & mk);
    end
    $display("reference test done");
    u_host_spi_model.frame(14'h0aaa, 16, got);
    check(converter_config_word, w);
    u_host_spi_model.frame(14'h3ff0, 10, got);
    check(serial_data_out_en_n, 1'b0);
    check(converter_config_word, w);
    $display("discard test done");
    w = {1'b1, 3'h7, 3'h5, 1'b1, 3'h2, 2'h0, 1'b0};
    u_host_spi_model.frame(w, 16, got);
    check(serial_data_out_en_n, 1'b1);
    u_host_spi_model.frame(w, 30, got);
    check(got[29:14], result_data);
    check(got[13:0], w);
    check(serial_data_out_en_n, 1'b1);
    u_host_spi_model.frame(w, 16, got);
    check(serial_data_out_en_n, 1'b0);
    $display("readback test done");
    for (int m = 3; m > 0; m--) begin
      u_host_spi_model.frame({1'b1, 3'h7, 3'h1, 1'b1, 3'h7, m[1:0], 1'b1}, 16, got);
      for (int i = 0; i < 4 && m > 1; i++) begin
        if (m == 2 && i == 2)
          check(mux_temp, 1'b1);
        else
          check(mux_channel, i % (m == 2 ? 3 : 2));
        u_host_spi_model.frame(14'h0, 16, got);
      end
    end
    u_host_spi_model.frame(14'h0, 16, got);
    check(mux_channel, 3'h1);
    check(mux_temp, 1'b1);
    check(pulses[29:0], 30'h17);
    check(result_ready, 1'b1);
    $display("sequencer test done");
    final_report();
  end
endmodule : test_adc_serial_config_readout
`default_nettype wire
